// ===== common/gip_map.svh
// What this block does
// (RULE_01) Sealed units power up in operate; mode commands pick operate, DC or AC calibration
// (RULE_02) Hold adapter reset low for a fixed interval after power-on
// (RULE_03) Program memory drives the data bus only while its select is low
// (RULE_04) Read with alternate select and the latch bit high returns switch settings
// (RULE_05) Adapter is selected only by chip select with the latch bit low
// (RULE_06) Address bits 0, 1 and the high port bit choose the control port
// (RULE_07) Control port read keeps control transmit enable off, lines flow inward
// (RULE_08) Control port write turns control transmit enable on, lines driven outward
// (RULE_09) Same address bits choose the data port for byte transfers
// (RULE_10) Data port write turns data transmit enable on, byte goes to the bus
// (RULE_11) Data port read turns data transmit enable off, bus byte flows inward
// (RULE_12) Every bus byte uses the three-wire source and acceptor handshake
// (RULE_13) All adapter sequencing runs on the instrument clock, not bus timing
// (RULE_14) Status byte bit 6 is set while service is requested
// (RULE_15) Enable command raises service request after each measurement; disable stops it
// (RULE_16) Freeze blocks new measurements until release; trigger or group trigger forces one
// (RULE_17) Switch latch and adapter release the data bus when not selected
`ifndef GIP_MAP_SVH
`define GIP_MAP_SVH

// Timing
`define GIP_CLK_NS      100
`define GIP_POR_NS      10000000
`define GIP_POR_CYC     ((`GIP_POR_NS + `GIP_CLK_NS - 1) / `GIP_CLK_NS)
`define GIP_SETTLE_NS   2000
`define GIP_SETTLE_CYC  ((`GIP_SETTLE_NS + `GIP_CLK_NS - 1) / `GIP_CLK_NS)
`define GIP_ECHO_CYC    6

// Adapter ports, index {a5, a1, a0}
`define GIP_PORT_DATA   3'h0
`define GIP_PORT_CTRL   3'h1
`define GIP_PORT_STAT   3'h2
`define GIP_PORT_CMD    3'h3

// Command codes on the command port, then the group trigger code taken from the bus
`define GIP_CMD_OPERATE 8'h80
`define GIP_CMD_DC_CAL  8'h81
`define GIP_CMD_AC_CAL  8'h82
`define GIP_CMD_SRQ_ON  8'h11
`define GIP_CMD_SRQ_OFF 8'h10
`define GIP_CMD_FREEZE  8'h21
`define GIP_CMD_RELEASE 8'h20
`define GIP_CMD_TRIG    8'h54
`define GIP_GET_CODE    8'h08

// Status byte fields
`define GIP_STAT_RXFULL 0
`define GIP_STAT_TXFULL 1
`define GIP_STAT_FREEZE 2
`define GIP_STAT_MODE   3
`define GIP_STAT_SRQ    6

// Transmit buffer
`define GIP_FIFO_W      8
`define GIP_FIFO_D      32

`endif

// ===== common/gip_pkg.sv
package gip_pkg;
  typedef enum logic [1:0] {GIP_MODE_OPERATE, GIP_MODE_DC_CAL, GIP_MODE_AC_CAL} gip_mode_t;
  typedef enum logic [1:0] {GIP_SRC_IDLE, GIP_SRC_SETTLE, GIP_SRC_DAV, GIP_SRC_REL} gip_src_t;
  typedef enum logic {GIP_ACC_IDLE, GIP_ACC_ACK} gip_acc_t;

  // Bus management and handshake lines, 1 = line true
  typedef struct packed {
    logic atn;
    logic eoi;
    logic srq;
    logic ren;
    logic ifc;
    logic dav;
    logic nrfd;
    logic ndac;
  } gip_ctl_t;

  // Processor strobes and address
  typedef struct packed {
    logic       rd_n;
    logic       wr_n;
    logic       interface_chip_select;
    logic       interface_chip_select_alt;
    logic       program_memory_select_n;
    logic [6:0] addr;
  } gip_cpu_t;
endpackage

// ===== design/gip_top.sv
`timescale 1ns/1ps
`include "gip_map.svh"

module gip_fifo #(
  parameter int W = `GIP_FIFO_W,
  parameter int D = `GIP_FIFO_D
) (
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  wire           push = in_valid & in_ready;
  wire           pop  = out_valid & out_ready;

  // Honest flags straight from the fill count
  assign in_ready  = cnt_q != (AW+1)'(D);
  assign out_valid = cnt_q != '0;
  assign out_data  = mem_q[rp_q];

  // Storage carries no reset
  always_ff @(posedge sys_clk) begin
    if (push) mem_q[wp_q] <= in_data;
  end

  // Pointers and count
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      if (push && !pop) cnt_q <= cnt_q + 1'b1;
      else if (pop && !push) cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

module gip_top #(
  parameter int unsigned POR_CYCLES = `GIP_POR_CYC
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire gip_pkg::gip_cpu_t cpu_bus,
  input  wire logic [7:0]       cpu_data_i,
  output logic [7:0]            cpu_data_o,
  output logic                  cpu_data_oe_n,
  input  wire logic [7:0]       gpib_dio_i,
  output logic [7:0]            gpib_dio_o,
  output logic [7:0]            gpib_dio_oe_n,
  input  wire logic [7:0]       gpib_ctl_i,
  output logic [7:0]            gpib_ctl_o,
  output logic [7:0]            gpib_ctl_oe_n,
  output logic                  data_transmit_enable,
  output logic                  ctl_transmit_enable,
  output logic                  adapter_reset_n,
  input  wire logic [7:0]       switch_setting,
  input  wire logic             sealed_switch,
  input  wire logic             meas_done,
  output logic                  meas_start,
  output logic                  reading_freeze,
  output gip_pkg::gip_mode_t    meas_mode,
  output logic                  srq_on_complete,
  output logic                  tx_space
);
  localparam int NS = 25;
  localparam logic [7:0] ROM [16] = '{
    8'h3e, 8'h01, 8'hd3, 8'h10, 8'hdb, 8'h11, 8'he6, 8'h40,
    8'hca, 8'h00, 8'h3a, 8'h12, 8'hc9, 8'h00, 8'h76, 8'hff};

  logic [NS-1:0]      s1_q;
  logic [NS-1:0]      s2_q;
  logic [NS-1:0]      s3_q;
  logic [NS-1:0]      flt_q;
  logic [23:0]        por_cnt_q;
  logic               adp_rst_n_q;
  logic               wr_prev_q;
  logic               rd_prev_q;
  logic [7:0]         cpu_do_q;
  logic               cpu_oe_n_q;
  logic [7:0]         dio_o_q;
  logic [7:0]         dio_oe_n_q;
  logic [7:0]         ctl_o_q;
  logic [7:0]         ctl_oe_n_q;
  logic               data_te_q;
  logic               ctl_te_q;
  gip_pkg::gip_ctl_t  ctl_drv_q;
  gip_pkg::gip_src_t  src_q;
  gip_pkg::gip_acc_t  acc_q;
  logic [4:0]         set_cnt_q;
  logic [2:0]         quiet_q;
  logic [7:0]         tx_q;
  logic [7:0]         rx_q;
  logic               rx_full_q;
  logic               get_q;
  gip_pkg::gip_mode_t mode_q;
  logic               srq_en_q;
  logic               srq_req_q;
  logic               freeze_q;
  logic               forced_q;
  logic               meas_start_q;
  logic               tx_space_q;
  logic [7:0]         stat_w;
  gip_pkg::gip_ctl_t  hs_w;
  logic [7:0]         fifo_d;
  logic               fifo_ov;
  logic               push_rdy;

  // Pin synchronisers, a change counts once stages two and three agree
  wire [NS-1:0] raw = {sealed_switch, switch_setting, gpib_ctl_i, gpib_dio_i};
  for (genvar i = 0; i < NS; i++) begin : g_sync
    always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
        s1_q[i]  <= 1'b1;  // Idle level, no false edge after reset
        s2_q[i]  <= 1'b1;
        s3_q[i]  <= 1'b1;
        flt_q[i] <= 1'b1;
      end else begin
        s1_q[i] <= raw[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) flt_q[i] <= s3_q[i];
      end
    end
  end

  // Bus lines are low-true, flip to 1 = true
  wire [7:0]         dio_t  = ~flt_q[7:0];
  gip_pkg::gip_ctl_t ctl_t;
  assign ctl_t = ~flt_q[15:8];
  wire [7:0]         sw_s   = flt_q[23:16];
  wire               sealed = flt_q[24];

  // Address decode
  wire       prom_en = ~cpu_bus.program_memory_select_n;  // [RULE_03]
  wire       sw_rd   = ~cpu_bus.rd_n & cpu_bus.interface_chip_select_alt & cpu_bus.addr[6];  // [RULE_04]
  wire       adp_sel = cpu_bus.interface_chip_select & ~cpu_bus.addr[6] & adp_rst_n_q;  // [RULE_05]
  wire [2:0] port    = {cpu_bus.addr[5], cpu_bus.addr[1], cpu_bus.addr[0]};  // [RULE_06] [RULE_09]
  wire       adp_rd  = adp_sel & ~cpu_bus.rd_n;
  wire       adp_wr  = adp_sel & ~cpu_bus.wr_n & cpu_bus.rd_n;
  wire       wr_p    = adp_wr & ~wr_prev_q;
  wire       rd_p    = adp_rd & ~rd_prev_q;
  wire       ctl_rd  = adp_rd & (port == `GIP_PORT_CTRL);
  wire       ctl_wr  = adp_wr & (port == `GIP_PORT_CTRL);
  wire       data_rd = adp_rd & (port == `GIP_PORT_DATA);
  wire       data_wr = adp_wr & (port == `GIP_PORT_DATA);
  wire       stat_rp = rd_p & (port == `GIP_PORT_STAT);
  wire       cmd_p   = wr_p & (port == `GIP_PORT_CMD);

  // Read selection, prom first so a stray overlap never fights
  wire [7:0] port_rd = (port == `GIP_PORT_DATA) ? rx_q :
                       (port == `GIP_PORT_CTRL) ? 8'(ctl_t) :
                       (port == `GIP_PORT_STAT) ? stat_w : 8'h00;
  wire [7:0] rd_word = prom_en ? ROM[cpu_bus.addr[3:0]] : sw_rd ? sw_s : port_rd;
  wire       drive   = prom_en | sw_rd | adp_rd;

  // Status byte
  always_comb begin
    stat_w = 8'h00;
    stat_w[`GIP_STAT_RXFULL] = rx_full_q;
    stat_w[`GIP_STAT_TXFULL] = ~push_rdy;
    stat_w[`GIP_STAT_FREEZE] = freeze_q;
    stat_w[`GIP_STAT_MODE +: 2] = mode_q;
    stat_w[`GIP_STAT_SRQ] = srq_req_q;  // [RULE_14]
  end

  // Transceiver direction, sticky control side
  wire ctl_te_d  = ctl_wr | (ctl_te_q & ~ctl_rd);  // [RULE_07] [RULE_08]
  wire src_busy  = (src_q != gip_pkg::GIP_SRC_IDLE) | fifo_ov;
  wire data_te_d = ~data_rd & (data_wr | src_busy);  // [RULE_10] [RULE_11]
  wire listen    = ~src_busy & (quiet_q == '0);  // Deaf until our own stale DAV leaves the synchroniser

  // Acceptor side decode
  wire acc_take = listen & (acc_q == gip_pkg::GIP_ACC_IDLE) & ctl_t.dav & ~rx_full_q;  // [RULE_12]
  wire rx_set   = acc_take & ~ctl_t.atn;
  wire get_hit  = acc_take & ctl_t.atn & (dio_t == `GIP_GET_CODE);

  // Handshake drives of our own
  always_comb begin
    hs_w      = '0;
    hs_w.dav  = src_q == gip_pkg::GIP_SRC_DAV;  // [RULE_12]
    hs_w.nrfd = listen & (rx_full_q | acc_q == gip_pkg::GIP_ACC_ACK);
    hs_w.ndac = listen & (acc_q == gip_pkg::GIP_ACC_IDLE);
    hs_w.srq  = srq_req_q;  // [RULE_15]
  end
  wire [7:0] ctl_drv_w = (ctl_te_d ? 8'(ctl_drv_q) : 8'h00) | 8'(hs_w);

  // Commands and forced measurement
  wire cmd_trig = cmd_p & (cpu_data_i == `GIP_CMD_TRIG);
  wire trig     = cmd_trig | get_q;  // [RULE_16]
  wire done_ok  = meas_done & (~freeze_q | forced_q);

  // Transmit buffer, CPU sees fullness in status and on tx_space
  gip_fifo #(.W(`GIP_FIFO_W), .D(`GIP_FIFO_D)) u_fifo (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .in_data   (cpu_data_i),
    .in_valid  (wr_p & data_wr),
    .in_ready  (push_rdy),
    .out_data  (fifo_d),
    .out_valid (fifo_ov),
    .out_ready (src_q == gip_pkg::GIP_SRC_IDLE)
  );

  // Power-on hold of the adapter, everything on the instrument clock
  always_ff @(posedge sys_clk or posedge sys_rst) begin  // [RULE_13]
    if (sys_rst) begin
      por_cnt_q   <= '0;
      adp_rst_n_q <= 1'b0;
    end else if (!adp_rst_n_q) begin
      por_cnt_q <= por_cnt_q + 1'b1;
      if (por_cnt_q == 24'(POR_CYCLES - 1)) adp_rst_n_q <= 1'b1;  // [RULE_02]
    end
  end

  // Processor data bus, released whenever no source is selected
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_do_q   <= 8'h00;
      cpu_oe_n_q <= 1'b1;
      wr_prev_q  <= 1'b0;
      rd_prev_q  <= 1'b0;
    end else begin
      cpu_do_q   <= rd_word;
      cpu_oe_n_q <= ~drive;  // [RULE_17]
      wr_prev_q  <= adp_wr;
      rd_prev_q  <= adp_rd;
    end
  end

  // Bus pin drivers, open drain: pull low where true
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dio_o_q    <= 8'h00;
      dio_oe_n_q <= 8'hff;
      ctl_o_q    <= 8'h00;
      ctl_oe_n_q <= 8'hff;
      data_te_q  <= 1'b0;
      ctl_te_q   <= 1'b0;
      ctl_drv_q  <= '0;
    end else begin
      dio_oe_n_q <= ~({8{data_te_d}} & tx_q);  // [RULE_10]
      ctl_oe_n_q <= ~ctl_drv_w;  // [RULE_08]
      data_te_q  <= data_te_d;
      ctl_te_q   <= ctl_te_d;
      if (wr_p && ctl_wr) ctl_drv_q <= cpu_data_i;
    end
  end

  // Source handshake: settle, wait ready, hold data valid until accepted
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      src_q     <= gip_pkg::GIP_SRC_IDLE;
      set_cnt_q <= '0;
      tx_q      <= 8'h00;
    end else begin
      case (src_q)
        gip_pkg::GIP_SRC_IDLE: begin
          if (fifo_ov) begin
            tx_q      <= fifo_d;
            set_cnt_q <= 5'(`GIP_SETTLE_CYC - 1);
            src_q     <= gip_pkg::GIP_SRC_SETTLE;
          end
        end
        gip_pkg::GIP_SRC_SETTLE: begin
          if (set_cnt_q != '0) set_cnt_q <= set_cnt_q - 1'b1;
          else if (!ctl_t.nrfd && ctl_t.ndac) src_q <= gip_pkg::GIP_SRC_DAV;  // [RULE_12]
        end
        gip_pkg::GIP_SRC_DAV: begin
          if (!ctl_t.ndac) src_q <= gip_pkg::GIP_SRC_REL;
        end
        gip_pkg::GIP_SRC_REL: begin
          src_q <= gip_pkg::GIP_SRC_IDLE;
        end
        default: src_q <= gip_pkg::GIP_SRC_IDLE;
      endcase
    end
  end

  // Acceptor handshake; a latch set beats a same-cycle read clear
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_q     <= gip_pkg::GIP_ACC_IDLE;
      rx_q      <= 8'h00;
      rx_full_q <= 1'b0;
      get_q     <= 1'b0;
      quiet_q   <= '0;
    end else begin
      get_q <= get_hit;  // [RULE_16]
      quiet_q <= src_busy ? 3'(`GIP_ECHO_CYC) : quiet_q - 3'(quiet_q != '0);  // [RULE_12]
      if (rx_set) rx_q <= dio_t;
      if (rx_set) rx_full_q <= 1'b1;
      else if (rd_p && data_rd) rx_full_q <= 1'b0;  // [RULE_11]
      case (acc_q)
        gip_pkg::GIP_ACC_IDLE: if (acc_take) acc_q <= gip_pkg::GIP_ACC_ACK;
        gip_pkg::GIP_ACC_ACK: if (!ctl_t.dav) acc_q <= gip_pkg::GIP_ACC_IDLE;
        default: acc_q <= gip_pkg::GIP_ACC_IDLE;
      endcase
    end
  end

  // Mode, service request and measurement control
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q       <= gip_pkg::GIP_MODE_OPERATE;  // [RULE_01]
      srq_en_q     <= 1'b0;
      srq_req_q    <= 1'b0;
      freeze_q     <= 1'b0;
      forced_q     <= 1'b0;
      meas_start_q <= 1'b0;
      tx_space_q   <= 1'b0;
    end else begin
      meas_start_q <= trig;  // [RULE_16]
      tx_space_q   <= push_rdy;
      if (cmd_p) begin
        case (cpu_data_i)
          `GIP_CMD_OPERATE: mode_q <= gip_pkg::GIP_MODE_OPERATE;  // [RULE_01]
          `GIP_CMD_DC_CAL:  if (sealed) mode_q <= gip_pkg::GIP_MODE_DC_CAL;
          `GIP_CMD_AC_CAL:  if (sealed) mode_q <= gip_pkg::GIP_MODE_AC_CAL;
          `GIP_CMD_SRQ_ON:  srq_en_q <= 1'b1;  // [RULE_15]
          `GIP_CMD_SRQ_OFF: srq_en_q <= 1'b0;
          `GIP_CMD_FREEZE:  freeze_q <= 1'b1;  // [RULE_16]
          `GIP_CMD_RELEASE: freeze_q <= 1'b0;
          default: ;
        endcase
      end
      if (trig) forced_q <= 1'b1;
      else if (meas_done) forced_q <= 1'b0;
      // Set wins over the serial poll clear
      if (done_ok && srq_en_q) srq_req_q <= 1'b1;  // [RULE_15]
      else if (stat_rp) srq_req_q <= 1'b0;
    end
  end

  // Outputs straight from flops
  assign cpu_data_o           = cpu_do_q;
  assign cpu_data_oe_n        = cpu_oe_n_q;
  assign gpib_dio_o           = dio_o_q;
  assign gpib_dio_oe_n        = dio_oe_n_q;
  assign gpib_ctl_o           = ctl_o_q;
  assign gpib_ctl_oe_n        = ctl_oe_n_q;
  assign data_transmit_enable = data_te_q;
  assign ctl_transmit_enable  = ctl_te_q;
  assign adapter_reset_n      = adp_rst_n_q;
  assign meas_start           = meas_start_q;
  assign reading_freeze       = freeze_q;
  assign meas_mode            = mode_q;
  assign srq_on_complete      = srq_en_q;
  assign tx_space             = tx_space_q;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  por_hold_a: assert property (!adp_rst_n_q |-> ##1 cpu_oe_n_q || $past(prom_en || sw_rd))  // [RULE_02]
    else $error("adapter answered during power-on hold");
  prom_out_a: assert property (prom_en |=> !cpu_oe_n_q && cpu_do_q == ROM[$past(cpu_bus.addr[3:0])])  // [RULE_03]
    else $error("program memory word not driven");
  switch_read_a: assert property (sw_rd && !prom_en |=> !cpu_oe_n_q && cpu_do_q == $past(sw_s))  // [RULE_04]
    else $error("switch latch not driven");
  adapter_gate_a: assert property (cpu_bus.addr[6] |-> !adp_rd && !adp_wr)  // [RULE_05]
    else $error("adapter selected with latch bit high");
  bus_release_a: assert property (!drive |=> cpu_oe_n_q)  // [RULE_17]
    else $error("data bus not released");
  ctl_te_rd_a: assert property (ctl_rd |=> !ctl_te_q)  // [RULE_07]
    else $error("control enable on during read");
  ctl_te_wr_a: assert property (ctl_wr |=> ctl_te_q)  // [RULE_08]
    else $error("control enable off during write");
  data_te_wr_a: assert property (data_wr |=> data_te_q)  // [RULE_10]
    else $error("data enable off during write");
  data_te_rd_a: assert property (data_rd |=> !data_te_q && dio_oe_n_q == 8'hff)  // [RULE_11]
    else $error("data enable on during read");
  dav_order_a: assert property (src_q == gip_pkg::GIP_SRC_SETTLE ##1 src_q == gip_pkg::GIP_SRC_DAV
    |-> $past(!ctl_t.nrfd && ctl_t.ndac && set_cnt_q == '0))  // [RULE_12]
    else $error("data valid before ready");
  srq_bit_a: assert property (srq_req_q |-> stat_w[`GIP_STAT_SRQ] && !ctl_oe_n_q[5] || $rose(srq_req_q))  // [RULE_14]
    else $error("status bit 6 or service line wrong");
  srq_set_a: assert property (done_ok && srq_en_q |=> srq_req_q)  // [RULE_15]
    else $error("service request lost");
  srq_off_a: assert property (!srq_en_q && !srq_req_q |=> !srq_req_q)  // [RULE_15]
    else $error("service request while disabled");
  trig_a: assert property (trig |=> meas_start_q ##1 !meas_start_q || $past(trig))  // [RULE_16]
    else $error("trigger did not start one measurement");
  cal_seal_a: assert property (cmd_p && cpu_data_i == `GIP_CMD_DC_CAL && !sealed
    |=> mode_q == $past(mode_q))  // [RULE_01]
    else $error("calibration mode entered unsealed");

  wr_flow_c: cover property (data_wr ##[1:200] src_q == gip_pkg::GIP_SRC_DAV);
  rx_flow_c: cover property (rx_set ##[1:50] rd_p && data_rd);
  srq_c: cover property (srq_req_q ##[1:50] stat_rp);
  get_c: cover property (get_q ##1 meas_start_q);
endmodule

// ===== testbench/gip_bus_model.sv
`timescale 1ns/1ps
// Far-side talker and listener; every line is open drain with a pull-up
module gip_bus_model (
  input  wire logic       sys_clk,
  input  wire logic       stall,
  input  wire logic [7:0] dio_oe_n,
  input  wire logic [7:0] ctl_oe_n,
  output logic [7:0]      dio_w,
  output logic [7:0]      ctl_w
);
  logic [7:0] p_dio_n = 8'hff;
  logic       atn_n   = 1'b1;
  logic       dav_n   = 1'b1;
  logic       nrfd_n  = 1'b1;
  logic       ndac_n  = 1'b0;
  logic       srcing  = 1'b0;
  logic       got     = 1'b0;
  logic [7:0] rxq[$];
  // Wired-and of both parties, released lines float high
  assign dio_w = dio_oe_n & p_dio_n;
  assign ctl_w = ctl_oe_n & {atn_n, 4'hf, dav_n, nrfd_n, ndac_n};
  // Listener; stall keeps ready low so the source must wait
  always @(posedge sys_clk) begin
    if (!srcing) begin
      if (!ctl_w[2] && !got) begin
        rxq.push_back(~dio_w);
        got    <= 1'b1;
        nrfd_n <= 1'b0;
        ndac_n <= 1'b1;
      end else if (ctl_w[2]) begin
        got    <= 1'b0;
        ndac_n <= 1'b0;
        nrfd_n <= !stall;
      end
    end
  end
  // Talker for one byte; waits are bounded so a dead acceptor cannot hang
  task automatic src(input logic [7:0] b, input logic atn);
    int i;
    srcing = 1'b1;
    @(posedge sys_clk);
    p_dio_n <= ~b;
    atn_n   <= !atn;
    nrfd_n  <= 1'b1;
    ndac_n  <= 1'b1;
    repeat (4) @(posedge sys_clk);
    // Ready needs NRFD released and NDAC still held by a live acceptor
    for (i = 0; i < 300 && !(ctl_w[1] && !ctl_w[0]); i++) @(posedge sys_clk);
    dav_n <= 1'b0;
    @(posedge sys_clk);
    for (i = 0; i < 300 && !ctl_w[0]; i++) @(posedge sys_clk);
    dav_n   <= 1'b1;
    p_dio_n <= 8'hff;
    atn_n   <= 1'b1;
    repeat (4) @(posedge sys_clk);
    srcing = 1'b0;
  endtask
endmodule

// ===== testbench/gpib_interface_port_logic_tb.sv
`timescale 1ns/1ps
`include "gip_map.svh"
module gpib_interface_port_logic_tb;
  localparam int POR = 8;
  localparam gip_pkg::gip_cpu_t IDLE = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 7'h00};
  logic               sys_clk = 1'b0;
  logic               sys_rst = 1'b1;
  logic               stall = 1'b0;
  logic               sealed_switch = 1'b1;
  logic               meas_done = 1'b0;
  gip_pkg::gip_cpu_t  cb = IDLE;
  logic [7:0]         dat = 8'h00;
  logic [7:0]         sw = 8'ha5;
  logic [7:0]         dio_w, ctl_w, dio_oe_n, ctl_oe_n, cpu_data_o, rdat, dio_o, ctl_o;
  logic               cpu_data_oe_n, roe, te_d, te_c, data_transmit_enable, ctl_transmit_enable;
  logic               adapter_reset_n, meas_start, reading_freeze, srq_on_complete, tx_space;
  gip_pkg::gip_mode_t meas_mode;
  logic [7:0]         mc[3] = '{8'h81, 8'h82, 8'h80};
  logic [7:0]         me[3] = '{8'h01, 8'h02, 8'h00};
  int                 err_count = 0, compares = 0, ms_cnt = 0, nc, n, base, i;

  gip_top #(.POR_CYCLES(POR)) uut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .cpu_bus(cb), .cpu_data_i(dat), .cpu_data_o(cpu_data_o),
    .cpu_data_oe_n(cpu_data_oe_n), .gpib_dio_i(dio_w), .gpib_dio_o(dio_o), .gpib_dio_oe_n(dio_oe_n),
    .gpib_ctl_i(ctl_w), .gpib_ctl_o(ctl_o), .gpib_ctl_oe_n(ctl_oe_n), .data_transmit_enable(data_transmit_enable),
    .ctl_transmit_enable(ctl_transmit_enable), .adapter_reset_n(adapter_reset_n), .switch_setting(sw),
    .sealed_switch(sealed_switch), .meas_done(meas_done), .meas_start(meas_start),
    .reading_freeze(reading_freeze), .meas_mode(meas_mode), .srq_on_complete(srq_on_complete),
    .tx_space(tx_space));
  gip_bus_model bm (.sys_clk(sys_clk), .stall(stall), .dio_oe_n(dio_oe_n), .ctl_oe_n(ctl_oe_n),
    .dio_w(dio_w), .ctl_w(ctl_w));

  // 10 MHz clock
  initial forever #50 sys_clk = ~sys_clk;
  // Count measurement start pulses
  always @(posedge sys_clk) if (meas_start === 1'b1) ms_cnt++;

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask
  // One access: level held one cycle, registered answer taken the edge after
  task automatic acc(input logic w, input logic [2:0] sel, input logic [6:0] a, input logic [7:0] d);
    cb.rd_n = w;
    cb.wr_n = !w;
    cb.interface_chip_select = sel[0];
    cb.interface_chip_select_alt = sel[1];
    cb.program_memory_select_n = !sel[2];
    cb.addr = a;
    dat = d;
    cyc(1);
    rdat = cpu_data_o;
    roe = cpu_data_oe_n;
    te_d = data_transmit_enable;
    te_c = ctl_transmit_enable;
    cb = IDLE;
    cyc(1);
  endtask
  task automatic wr(input logic [1:0] p, input logic [7:0] d);
    acc(1'b1, 3'b001, {5'h00, p}, d);
  endtask
  task automatic rd(input logic [1:0] p);
    acc(1'b0, 3'b001, {5'h00, p}, 8'h00);
  endtask
  task automatic done_pulse;
    meas_done = 1'b1;
    cyc(1);
    meas_done = 1'b0;
    cyc(2);
  endtask
  task automatic tend(input string s);
    $display("test %s finished", s);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog, well beyond the under two thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    test_done;
  end

  initial begin
    cyc(8);
    sys_rst = 1'b0;
    rd(2'h2);
    chk("early access oe_n", 8'h01, {7'h00, roe});
    for (nc = 2; nc < 50 && adapter_reset_n !== 1'b1; nc++) cyc(1);
    chk("reset hold", 8'(POR), 8'(nc));
    chk("power-up mode", 8'h00, 8'(meas_mode));
    tend("power-on");
    acc(1'b0, 3'b100, 7'h00, 8'h00);
    chk("rom oe_n", 8'h00, {7'h00, roe});
    chk("rom release", 8'h01, {7'h00, cpu_data_oe_n});
    acc(1'b0, 3'b010, 7'h40, 8'h00);
    chk("switch latch", sw, rdat);
    acc(1'b0, 3'b001, 7'h42, 8'h00);
    chk("latch bit refuse", 8'h01, {7'h00, roe});
    wr(2'h1, 8'h00);
    chk("ctl write te", 8'h01, {7'h00, te_c});
    rd(2'h1);
    chk("ctl read te", 8'h00, {7'h00, te_c});
    acc(1'b1, 3'b001, 7'h21, 8'h00);
    chk("high port bit te", 8'h00, {7'h00, te_c});
    tend("decode");
    // Fill the transmit buffer against a stalled listener, then drain
    stall = 1'b1;
    base = bm.rxq.size();
    for (n = 0; n < 40 && tx_space === 1'b1; n++) begin
      wr(2'h0, 8'(n));
      if (n == 0) chk("data write te", 8'h01, {7'h00, te_d});
      cyc(1);
    end
    chk("bytes taken", 8'(`GIP_FIFO_D + 1), 8'(n));
    rd(2'h2);
    chk("tx full", 8'h01, {7'h00, rdat[1]});
    stall = 1'b0;
    for (i = 0; i < 3000 && bm.rxq.size() < base + n; i++) cyc(1);
    for (i = 0; i < n; i++) chk("bus byte", 8'(i), bm.rxq[base+i]);
    chk("open drain level", 8'h00, dio_o | ctl_o);
    tend("source");
    bm.src(8'h5a, 1'b0);
    cyc(6);
    rd(2'h2);
    chk("rx full", 8'h01, {7'h00, rdat[0]});
    rd(2'h0);
    chk("rx byte", 8'h5a, rdat);
    chk("data read te", 8'h00, {7'h00, te_d});
    tend("acceptor");
    wr(2'h3, `GIP_CMD_SRQ_ON);
    chk("srq enable", 8'h01, {7'h00, srq_on_complete});
    base = ms_cnt;
    wr(2'h3, `GIP_CMD_TRIG);
    cyc(2);
    chk("trigger start", 8'(base + 1), 8'(ms_cnt));
    done_pulse();
    chk("srq line", 8'h00, {7'h00, ctl_oe_n[5]});
    rd(2'h2);
    chk("status srq", 8'h01, {7'h00, rdat[6]});
    rd(2'h2);
    chk("srq cleared", 8'h00, {7'h00, rdat[6]});
    wr(2'h3, `GIP_CMD_FREEZE);
    chk("freeze", 8'h01, {7'h00, reading_freeze});
    done_pulse();
    rd(2'h2);
    chk("frozen no srq", 8'h00, {7'h00, rdat[6]});
    wr(2'h3, `GIP_CMD_TRIG);
    done_pulse();
    rd(2'h2);
    chk("forced srq", 8'h01, {7'h00, rdat[6]});
    wr(2'h3, `GIP_CMD_RELEASE);
    chk("release", 8'h00, {7'h00, reading_freeze});
    wr(2'h3, `GIP_CMD_SRQ_OFF);
    done_pulse();
    rd(2'h2);
    chk("srq off", 8'h00, {7'h00, rdat[6]});
    base = ms_cnt;
    bm.src(`GIP_GET_CODE, 1'b1);
    cyc(8);
    chk("group trigger", 8'(base + 1), 8'(ms_cnt));
    tend("service");
    for (i = 0; i < 3; i++) begin
      wr(2'h3, mc[i]);
      chk("mode", me[i], 8'(meas_mode));
    end
    sealed_switch = 1'b0;
    cyc(6);
    wr(2'h3, `GIP_CMD_DC_CAL);
    chk("unsealed cal", 8'h00, 8'(meas_mode));
    tend("modes");
    test_done();
  end
endmodule
